// ### aba_defs.svh
// Purpose: Named constants of the byte-wide block cipher accelerator.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef ABA_DEFS_SVH
`define ABA_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ABA_OFS_CTRL     2'h0
`define ABA_OFS_STATUS   2'h1
`define ABA_OFS_DIN      2'h2
`define ABA_OFS_DOUT     2'h3

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define ABA_CR_EN        0
`define ABA_CR_MODE_LO   1
`define ABA_CR_MODE_HI   2
`define ABA_CR_DONE_CLR  3
`define ABA_CR_ERR_CLR   4
`define ABA_CR_DONE_IE   5
`define ABA_CR_ERR_IE    6
`define ABA_CR_DMA_EN    7

// ----------------------------------------------------------------------
// Mode codes, last byte indices, computation lengths in clock cycles and reset values
// ----------------------------------------------------------------------
`define ABA_MODE_ENC     2'h0
`define ABA_MODE_KDER    2'h1
`define ABA_MODE_DEC     2'h2
`define ABA_MODE_KDDEC   2'h3
`define ABA_IN_LAST_LONG 5'h1f
`define ABA_IN_LAST_KEY  5'h0f
`define ABA_OUT_LAST     4'hf
`define ABA_CYC_ENCDEC   11'h37c
`define ABA_CYC_KDER     11'h140
`define ABA_CYC_KDDEC    11'h4cc
`define ABA_RST_BYTE     8'h00
`define ABA_RST_BLOCK    128'h0

`endif

// ### aba_pkg.sv
// Purpose: Types shared by the accelerator files.
// Assumes: Constants live in aba_defs.svh.
// Notes:   Types only.
package aba_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_INPUT, ST_COMPUTE, ST_OUTPUT} aba_state_e;
  typedef logic [1:0] aba_mode_t;
endpackage : aba_pkg

// ### aba_result_mem.sv
// Purpose: Sixteen-byte result store with a registered read port.
// Assumes: Whole block is loaded in one cycle; bytes are read by index.
// Notes:   Index 0 is the most significant byte of the block.
`timescale 1ns/1ps
`include "aba_defs.svh"
module aba_result_mem
  import aba_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_load,
  input  wire logic [127:0] i_block,
  input  wire logic [3:0]   i_idx,
  output logic      [7:0]   o_byte
);
  logic [7:0] mem_q [16];
  logic [7:0] mem_d [16];
  logic [7:0] byte_d;
  logic [7:0] byte_q;

  // Bypass on load so the first byte is valid in the cycle after the load.
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_ent
      always_comb begin
        mem_d[g] = i_load ? i_block[127-8*g -: 8] : mem_q[g];
      end
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          mem_q[g] <= `ABA_RST_BYTE;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate

  always_comb begin
    byte_d = mem_d[i_idx];
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      byte_q <= `ABA_RST_BYTE;
    end else begin
      byte_q <= byte_d;
    end
  end

  assign o_byte = byte_q;
endmodule : aba_result_mem

// ### aba_engine.sv
// Purpose: Iterative block transform with mode-dependent run length.
// Assumes: Key and block are stable in the start cycle.
// Notes:   The round datapath is a compact mixing stand-in; the run length is exact.
`timescale 1ns/1ps
`include "aba_defs.svh"
module aba_engine
  import aba_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_start,
  input  wire logic         i_abort,
  input  wire aba_mode_t    i_mode,
  input  wire logic [127:0] i_key,
  input  wire logic [127:0] i_blk,
  output logic              o_done,
  output logic      [127:0] o_result
);
  logic [10:0]  cnt_q, cnt_d;
  logic         busy_q, busy_d;
  logic [127:0] s_q, s_d, k_q, k_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    s_d    = s_q;
    k_d    = k_q;
    o_done = busy_q && (cnt_q == 11'h000);
    if (i_abort) begin
      busy_d = 1'b0;
    end else if (i_start) begin
      busy_d = 1'b1;
      k_d    = i_key;
      s_d    = (i_mode == `ABA_MODE_KDER) ? i_key : i_blk;
      unique case (i_mode)
        `ABA_MODE_KDER:  cnt_d = `ABA_CYC_KDER - 11'h001;
        `ABA_MODE_KDDEC: cnt_d = `ABA_CYC_KDDEC - 11'h001;
        default:         cnt_d = `ABA_CYC_ENCDEC - 11'h001;
      endcase
    end else if (busy_q) begin
      s_d = {s_q[126:0], s_q[127]} ^ k_q;
      k_d = {k_q[119:0], k_q[127:120]};
      if (o_done) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 11'h001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_q  <= 11'h000;
      busy_q <= 1'b0;
      s_q    <= `ABA_RST_BLOCK;
      k_q    <= `ABA_RST_BLOCK;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      s_q    <= s_d;
      k_q    <= k_d;
    end
  end

  assign o_result = s_q;
endmodule : aba_engine

// ### aba_accel.sv
// Purpose: Byte-wide 128-bit block cipher accelerator with register port and DMA requests.
// Assumes: Single 20 MHz clock, synchronous active-low reset, one-cycle strobes.
// Notes:   Read data stand only in the cycle after the read strobe.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "aba_defs.svh"

// Function
// - 128-bit blocks, 128-bit key, key derivation
// - Mode field: enc, kder, dec, kder+dec
// - Enable enters input phase, 32/16 bytes
// - Last byte starts compute; done sets flag
// - Done flag with its enable raises interrupt
// - Sixteen result bytes out, MSB first
// - Any idle time between accesses tolerated
// - Output read in input/compute: read error
// - Input write in compute/output: write error
// - Error flag with enable raises interrupt
// - Errors do not disable or stop processing
// - Disable reinitializes; enable restarts input phase
// - DMA input request while bytes needed
// - DMA output request while result waits
// - DMA runs until disabled, blocks loop
// - Compute lasts 892, 320 or 1228 cycles
// - Error clear bit clears both, reads zero
// - Done clear bit clears flag, reads zero
module aba_accel
  import aba_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  output logic            o_dma_in_req,
  output logic            o_dma_out_req
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  aba_state_e   st_q, st_d;
  aba_mode_t    mode_q, mode_d;
  logic         en_q, en_d;
  logic         dma_q, dma_d;
  logic         done_ie_q, done_ie_d;
  logic         err_ie_q, err_ie_d;
  logic         done_q, done_d;
  logic         read_error_flag_q, read_error_flag_d;
  logic         write_error_flag_q, write_error_flag_d;
  logic [4:0]   in_cnt_q, in_cnt_d;
  logic [3:0]   out_cnt_q, out_cnt_d;
  logic [127:0] key_q, key_d, blk_q, blk_d;
  logic [7:0]   din_q, din_d;
  logic [7:0]   rdata_q, rdata_d;

  logic         ctrl_wr, din_wr, dout_rd;
  logic         in_last, start, eng_done;
  logic [4:0]   in_need;
  logic [127:0] eng_result;
  logic [7:0]   out_byte;

  assign ctrl_wr = i_wr && (i_addr == `ABA_OFS_CTRL);
  assign din_wr  = i_wr && (i_addr == `ABA_OFS_DIN);
  assign dout_rd = i_rd && (i_addr == `ABA_OFS_DOUT);
  assign in_need = (mode_q == `ABA_MODE_KDER) ? `ABA_IN_LAST_KEY : `ABA_IN_LAST_LONG;
  assign in_last = (in_cnt_q == in_need);
  assign start   = (st_q == ST_INPUT) && din_wr && in_last;

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  aba_engine u_engine (
    .i_clk    (i_clk),
    .i_nrst   (i_nrst),
    .i_start  (start),
    .i_abort  (!en_q),
    .i_mode   (mode_q),
    .i_key    (key_d),
    .i_blk    (blk_d),
    .o_done   (eng_done),
    .o_result (eng_result)
  );

  aba_result_mem u_result (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_load  (eng_done),
    .i_block (eng_result),
    .i_idx   (out_cnt_d),
    .o_byte  (out_byte)
  );

  // --------------------------------------------------------------------
  // Control, sequencing and flags
  // --------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    mode_d    = mode_q;
    en_d      = en_q;
    dma_d     = dma_q;
    done_ie_d = done_ie_q;
    err_ie_d  = err_ie_q;
    in_cnt_d  = in_cnt_q;
    out_cnt_d = out_cnt_q;
    key_d     = key_q;
    blk_d     = blk_q;
    din_d     = din_q;
    if (din_wr) begin
      din_d = i_wdata;
    end
    unique case (st_q)
      ST_IDLE: begin
      end
      ST_INPUT: begin
        // Outside kder, even bytes feed the key and odd bytes the block, so the host interleaves them; in kder every byte feeds the key.
        if (din_wr) begin
          if ((mode_q == `ABA_MODE_KDER) || !in_cnt_q[0]) begin
            key_d = {key_q[119:0], i_wdata};
          end else begin
            blk_d = {blk_q[119:0], i_wdata};
          end
          in_cnt_d = in_cnt_q + 5'h01;
          if (in_last) begin
            st_d     = ST_COMPUTE;
            in_cnt_d = 5'h00;
          end
        end
      end
      ST_COMPUTE: begin
        if (eng_done) begin
          st_d      = ST_OUTPUT;
          out_cnt_d = 4'h0;
        end
      end
      ST_OUTPUT: begin
        if (dout_rd) begin
          out_cnt_d = out_cnt_q + 4'h1;
          if (out_cnt_q == `ABA_OUT_LAST) begin
            st_d = ST_INPUT;
          end
        end
      end
    endcase
    if (ctrl_wr) begin
      en_d      = i_wdata[`ABA_CR_EN];
      dma_d     = i_wdata[`ABA_CR_DMA_EN];
      done_ie_d = i_wdata[`ABA_CR_DONE_IE];
      err_ie_d  = i_wdata[`ABA_CR_ERR_IE];
      // A mode write while enabled is ignored rather than corrupting a block.
      if (!en_q) begin
        mode_d = i_wdata[`ABA_CR_MODE_HI:`ABA_CR_MODE_LO];
      end
      if (!i_wdata[`ABA_CR_EN]) begin
        st_d      = ST_IDLE;
        in_cnt_d  = 5'h00;
        out_cnt_d = 4'h0;
      end else if (!en_q) begin
        st_d      = ST_INPUT;
        in_cnt_d  = 5'h00;
        out_cnt_d = 4'h0;
      end
    end
  end

  // Set wins over clear for every hardware flag.
  always_comb begin
    done_d  = done_q;
    read_error_flag_d = read_error_flag_q;
    write_error_flag_d = write_error_flag_q;
    if (ctrl_wr && i_wdata[`ABA_CR_DONE_CLR]) begin
      done_d = 1'b0;
    end
    if (ctrl_wr && i_wdata[`ABA_CR_ERR_CLR]) begin
      read_error_flag_d = 1'b0;
      write_error_flag_d = 1'b0;
    end
    if (eng_done && (st_q == ST_COMPUTE)) begin
      done_d = 1'b1;
    end
    if (dout_rd && ((st_q == ST_INPUT) || (st_q == ST_COMPUTE))) begin
      read_error_flag_d = 1'b1;
    end
    if (din_wr && ((st_q == ST_COMPUTE) || (st_q == ST_OUTPUT))) begin
      write_error_flag_d = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------
  always_comb begin
    rdata_d = `ABA_RST_BYTE;
    if (i_rd) begin
      unique case (i_addr)
        `ABA_OFS_CTRL:   rdata_d = {dma_q, err_ie_q, done_ie_q, 2'b00, mode_q, en_q};
        `ABA_OFS_STATUS: rdata_d = {5'h00, write_error_flag_q, read_error_flag_q, done_q};
        `ABA_OFS_DIN:    rdata_d = din_q;
        `ABA_OFS_DOUT:   rdata_d = (st_q == ST_OUTPUT) ? out_byte : `ABA_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_q      <= ST_IDLE;
      mode_q    <= `ABA_MODE_ENC;
      en_q      <= 1'b0;
      dma_q     <= 1'b0;
      done_ie_q <= 1'b0;
      err_ie_q  <= 1'b0;
      done_q    <= 1'b0;
      read_error_flag_q   <= 1'b0;
      write_error_flag_q   <= 1'b0;
      in_cnt_q  <= 5'h00;
      out_cnt_q <= 4'h0;
      key_q     <= `ABA_RST_BLOCK;
      blk_q     <= `ABA_RST_BLOCK;
      din_q     <= `ABA_RST_BYTE;
      rdata_q   <= `ABA_RST_BYTE;
    end else begin
      st_q      <= st_d;
      mode_q    <= mode_d;
      en_q      <= en_d;
      dma_q     <= dma_d;
      done_ie_q <= done_ie_d;
      err_ie_q  <= err_ie_d;
      done_q    <= done_d;
      read_error_flag_q   <= read_error_flag_d;
      write_error_flag_q   <= write_error_flag_d;
      in_cnt_q  <= in_cnt_d;
      out_cnt_q <= out_cnt_d;
      key_q     <= key_d;
      blk_q     <= blk_d;
      din_q     <= din_d;
      rdata_q   <= rdata_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign o_rdata       = rdata_q;
  assign o_irq         = (done_q && done_ie_q) || ((read_error_flag_q || write_error_flag_q) && err_ie_q);
  // Level requests held for the whole input or output phase; the DMA keeps issuing single-byte accesses while one is high.
  assign o_dma_in_req  = dma_q && (st_q == ST_INPUT);
  assign o_dma_out_req = dma_q && (st_q == ST_OUTPUT);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic [10:0] comp_len_q, comp_len_d, dur_chk;

  always_comb begin
    comp_len_d = (st_q == ST_COMPUTE) ? (comp_len_q + 11'h001) : 11'h000;
    unique case (mode_q)
      `ABA_MODE_KDER:  dur_chk = `ABA_CYC_KDER;
      `ABA_MODE_KDDEC: dur_chk = `ABA_CYC_KDDEC;
      default:         dur_chk = `ABA_CYC_ENCDEC;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      comp_len_q <= 11'h000;
    end else begin
      comp_len_q <= comp_len_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_input_count: assert property ((st_q == ST_INPUT) && din_wr && (in_cnt_q == in_need) && !ctrl_wr
    |=> (st_q == ST_COMPUTE) && (in_cnt_q == 5'h00)) else $error("input phase did not end on last byte");
  a_compute_length: assert property ((st_q == ST_COMPUTE) && (st_d == ST_OUTPUT)
    |-> (comp_len_q == dur_chk - 11'h001)) else $error("computation phase length wrong");
  a_done_flag_set: assert property ((st_q == ST_COMPUTE) && eng_done && !ctrl_wr |=> done_q && (st_q == ST_OUTPUT))
    else $error("done flag not set at end of computation");
  a_done_irq: assert property (done_q && done_ie_q |-> o_irq) else $error("done interrupt missing");
  a_read_error: assert property (dout_rd && !eng_done && ((st_q == ST_INPUT) || (st_q == ST_COMPUTE))
    |=> read_error_flag_q && $stable(st_q)) else $error("read error not flagged");
  a_write_error: assert property (din_wr && ((st_q == ST_COMPUTE) || (st_q == ST_OUTPUT))
    |=> write_error_flag_q && ((st_q == ST_COMPUTE) || (st_q == ST_OUTPUT)))
    else $error("write error not flagged or processing left");
  a_disable_reinit: assert property (ctrl_wr && !i_wdata[`ABA_CR_EN]
    |=> (st_q == ST_IDLE) && !o_dma_in_req && !o_dma_out_req) else $error("disable did not reinitialize");
  a_block_loop: assert property ((st_q == ST_OUTPUT) && dout_rd && (out_cnt_q == `ABA_OUT_LAST) && !ctrl_wr
    |=> (st_q == ST_INPUT) && (o_dma_in_req == dma_q)) else $error("no return to input phase");
  a_error_clear: assert property (ctrl_wr && i_wdata[`ABA_CR_ERR_CLR] && !din_wr
    |=> !read_error_flag_q && !write_error_flag_q) else $error("error flags not cleared");

  c_encrypt_block: cover property ((mode_q == `ABA_MODE_ENC) && (st_q == ST_OUTPUT) && (out_cnt_q == `ABA_OUT_LAST) && dout_rd);
  c_key_derive: cover property ((mode_q == `ABA_MODE_KDER) && eng_done);
  c_dma_loop: cover property (dma_q && (st_q == ST_OUTPUT) ##1 (st_q == ST_INPUT));
  c_error_irq: cover property (err_ie_q && write_error_flag_q && o_irq);
endmodule : aba_accel

// ### aba_dma_model.sv
// Purpose: Byte-wide DMA controller model serving the input and output requests.
// Assumes: Requests are levels; one transfer is issued, then one idle cycle lets them settle.
// Notes:   Counts transfers so the bench can check how many each channel moved.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Transfer engine
// ----------------------------------------------------------------------
module aba_dma_model (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_en,
  input  wire logic       i_in_req,
  input  wire logic       i_out_req,
  output logic      [1:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  output int              o_in_cnt,
  output int              o_out_cnt
);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_addr    <= 2'h0;
      o_wdata   <= 8'h00;
      o_wr      <= 1'b0;
      o_rd      <= 1'b0;
      o_in_cnt  <= 0;
      o_out_cnt <= 0;
    end else begin
      o_wr    <= 1'b0;
      o_rd    <= 1'b0;
      // A released data bus shows no stale byte, so it toggles every idle cycle.
      o_wdata <= ~o_wdata;
      if (i_en && !o_wr && !o_rd) begin
        if (i_in_req) begin
          o_addr   <= 2'h2;
          o_wdata  <= o_in_cnt[7:0] ^ 8'ha5;
          o_wr     <= 1'b1;
          o_in_cnt <= o_in_cnt + 1;
        end else if (i_out_req) begin
          o_addr    <= 2'h3;
          o_rd      <= 1'b1;
          o_out_cnt <= o_out_cnt + 1;
        end
      end
    end
  end
endmodule : aba_dma_model

// ### aba_accel_tb.sv
// Purpose: Self-checking bench for the block cipher accelerator.
// Assumes: Register port with one-cycle strobes; read data in the next cycle only.
// Notes:   Cipher values are a stand-in, so timing, phases and flags are checked.
`timescale 1ns/1ps
`include "aba_defs.svh"
module aba_accel_tb;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  logic       clk;
  logic       nrst;
  logic [1:0] c_addr, d_addr, addr;
  logic [7:0] c_wdata, d_wdata, wdata, rdata, v, ctl;
  logic       c_wr, c_rd, d_wr, d_rd, wr, rd, irq, in_req, out_req, dma_on;
  int         d_in, d_out, fails, checked, n, nb, cyc;

  assign addr  = dma_on ? d_addr : c_addr;
  assign wdata = dma_on ? d_wdata : c_wdata;
  assign wr    = dma_on ? d_wr : c_wr;
  assign rd    = dma_on ? d_rd : c_rd;

  aba_accel u_dut (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
                   .o_rdata(rdata), .o_irq(irq), .o_dma_in_req(in_req), .o_dma_out_req(out_req));
  aba_dma_model u_dma (.i_clk(clk), .i_nrst(nrst), .i_en(dma_on), .i_in_req(in_req), .i_out_req(out_req),
                       .o_addr(d_addr), .o_wdata(d_wdata), .o_wr(d_wr), .o_rd(d_rd),
                       .o_in_cnt(d_in), .o_out_cnt(d_out));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------------
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    c_addr  <= a;
    c_wdata <= d;
    c_wr    <= 1'b1;
    @(posedge clk);
    c_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    c_addr <= a;
    c_rd   <= 1'b1;
    @(posedge clk);
    c_rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_i(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fails++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_i

  task automatic chk_reg(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : chk_reg

  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // Counts cycles until the interrupt rises; a lost interrupt ends the run.
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (irq !== 1'b1) begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 2000) begin
        fails++;
        $display("[FAIL] %0t interrupt never came", $time);
        end_sim();
      end
    end
  endtask : wait_irq

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    fails = 0;
    checked = 0;
    nrst = 1'b0;
    c_addr = 2'h0;
    c_wdata = 8'h00;
    c_wr = 1'b0;
    c_rd = 1'b0;
    dma_on = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk({in_req, out_req, irq, 5'h00}, 8'h00);
    chk_reg(`ABA_OFS_CTRL, 8'h00);
    chk_reg(`ABA_OFS_DOUT, 8'h00);
    wr_reg(`ABA_OFS_STATUS, 8'hff);
    chk_reg(`ABA_OFS_STATUS, 8'h00);
    for (int m = 0; m < 4; m++) begin
      nb  = (m == 1) ? 16 : 32;
      cyc = (m == 1) ? `ABA_CYC_KDER : (m == 3) ? `ABA_CYC_KDDEC : `ABA_CYC_ENCDEC;
      ctl = 8'h21 | {5'h00, m[1:0], 1'b0};
      wr_reg(`ABA_OFS_CTRL, ctl & 8'hfe);
      wr_reg(`ABA_OFS_CTRL, ctl);
      repeat (5) wr_reg(`ABA_OFS_DIN, 8'h5a);
      wr_reg(`ABA_OFS_CTRL, ctl & 8'hfe);
      wr_reg(`ABA_OFS_CTRL, ctl);
      chk_reg(`ABA_OFS_DOUT, 8'h00);
      chk_reg(`ABA_OFS_STATUS, 8'h02);
      wr_reg(`ABA_OFS_CTRL, ctl | 8'h10);
      chk_reg(`ABA_OFS_CTRL, ctl);
      for (int i = 0; i < nb; i++) begin
        wr_reg(`ABA_OFS_DIN, i[7:0]);
        repeat (i % 3) @(posedge clk);
      end
      // The last idle gap and the stray accesses fill four or five cycles before the wait.
      wr_reg(`ABA_OFS_DIN, 8'h33);
      rd_reg(`ABA_OFS_DOUT, v);
      wait_irq(n);
      chk_i(n, cyc - 4 - ((nb - 1) % 3));
      chk_reg(`ABA_OFS_STATUS, 8'h07);
      wr_reg(`ABA_OFS_CTRL, ctl | 8'h10);
      chk_reg(`ABA_OFS_STATUS, 8'h01);
      wr_reg(`ABA_OFS_DIN, 8'h44);
      chk_reg(`ABA_OFS_STATUS, 8'h05);
      wr_reg(`ABA_OFS_CTRL, ctl | 8'h10);
      repeat (16) rd_reg(`ABA_OFS_DOUT, v);
      chk_reg(`ABA_OFS_STATUS, 8'h01);
      wr_reg(`ABA_OFS_DIN, 8'h00);
      chk_reg(`ABA_OFS_STATUS, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr_reg(`ABA_OFS_CTRL, ctl | 8'h08);
      chk_reg(`ABA_OFS_CTRL, ctl);
      chk_reg(`ABA_OFS_STATUS, 8'h00);
      chk({7'h00, irq}, 8'h00);
    end
    wr_reg(`ABA_OFS_CTRL, 8'h41);
    rd_reg(`ABA_OFS_DOUT, v);
    chk({7'h00, irq}, 8'h01);
    wr_reg(`ABA_OFS_CTRL, 8'h51);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr_reg(`ABA_OFS_CTRL, 8'h00);
    wr_reg(`ABA_OFS_CTRL, 8'h81);
    #1;
    chk({in_req, out_req, 6'h00}, 8'h80);
    dma_on = 1'b1;
    n = 0;
    while (d_in < 64 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 5000) begin
      fails++;
      $display("[FAIL] %0t DMA transfers never finished", $time);
      end_sim();
    end
    chk_i(d_out, 16);
    chk_i(d_in, 64);
    repeat (2) @(posedge clk);
    #1;
    chk({in_req, out_req, 6'h00}, 8'h00);
    dma_on = 1'b0;
    chk_reg(`ABA_OFS_STATUS, 8'h01);
    wr_reg(`ABA_OFS_CTRL, 8'h88);
    chk_reg(`ABA_OFS_STATUS, 8'h00);
    chk({in_req, out_req, 6'h00}, 8'h00);
    end_sim();
  end
endmodule : aba_accel_tb
